/* rxff_consts.svh */
/*
  Constants for the receive frame filter and acknowledge decision block.
  Assumes byte addressing on the register bus, one 32-bit word per register.
*/
// Operation
// RQ1: Frames with a bad frame check are discarded before any address filtering.
// RQ2: Promiscuous mode forwards every good frame without further filtering.
// RQ3: Promiscuous mode raises a data indication for every good frame.
// RQ4: Promiscuous mode never sends an automatic acknowledgement.
// RQ5: Active promiscuous mode acknowledges frames passing normal address filtering.
// RQ6: Active promiscuous mode indicates every good frame, acknowledged or not.
// RQ7: An option also indicates frames whose frame check failed.
// RQ8: A frame with a bad frame check is never acknowledged.
// RQ9: Network identifier and short address of all ones are broadcast.
// RQ10: Valid non-broadcast data or command frames requesting it are acknowledged.
// RQ11: Broadcast network with matching extended destination is acknowledged.
// RQ12: That broadcast long-address acknowledgement also applies in active promiscuous.
// RQ13: Each network holds its own coordinator flag, one means coordinator.
// RQ14: Second network has a writable four-bit channel selector.
// RQ15: Second network holds identifier, short and extended address.
// RQ16: First network holds a writable 64-bit extended address.
// RQ17: Short addressing acknowledges only when neither identifier nor address is broadcast.
// RQ18: A read-write bit selects active promiscuous, cleared at reset.
// RQ19: First network holds channel selector, identifier and short address.
// RQ20: Read-only flags show which network the last frame arrived on.
// RQ21: Active promiscuous stores received acknowledgement frames in the buffer.
`ifndef RXFF_CONSTS_SVH
`define RXFF_CONSTS_SVH

// ----------------------------------------
// Register word indices (byte = 4 * index)
// ----------------------------------------
`define RXF_IDX_CTRL      4'h0
`define RXF_IDX_STATUS    4'h1
`define RXF_IDX_N0_CFG    4'h2
`define RXF_IDX_N0_PAN    4'h3
`define RXF_IDX_N0_SHORT  4'h4
`define RXF_IDX_N0_EXT_LO 4'h5
`define RXF_IDX_N0_EXT_HI 4'h6
`define RXF_IDX_N1_CFG    4'h7
`define RXF_IDX_N1_PAN    4'h8
`define RXF_IDX_N1_SHORT  4'h9
`define RXF_IDX_N1_EXT_LO 4'ha
`define RXF_IDX_N1_EXT_HI 4'hb
`define RXF_REG_COUNT     12

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define RXF_CTRL_PROMISC  0
`define RXF_CTRL_ACTIVE   1
`define RXF_CTRL_FAIL_IND 2
`define RXF_CFG_COORD     4
`define RXF_MASK_CTRL     32'h0000_0007
`define RXF_MASK_CFG      32'h0000_001f
`define RXF_MASK_HALF     32'h0000_ffff
`define RXF_MASK_FULL     32'hffff_ffff
`define RXF_MASK_NONE     32'h0000_0000
`define RXF_RESET_VALUE   32'h0000_0000

// ----------------------------------------
// Broadcast value
// ----------------------------------------
`define RXF_BROADCAST     16'hffff

`endif

/* rxff_pkg.sv */
/*
  Types for the receive frame filter and acknowledge decision block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rxff_pkg;

  // ----------------------------------------
  // Bus handshake states
  // ----------------------------------------
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_type;

  // ----------------------------------------
  // Frame kinds and addressing modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    FRAME_BEACON = 3'h0,
    FRAME_DATA   = 3'h1,
    FRAME_ACK    = 3'h2,
    FRAME_CMD    = 3'h3
  } frame_kind_type;

  typedef enum logic [1:0] {
    ADDR_NONE  = 2'h0,
    ADDR_RSVD  = 2'h1,
    ADDR_SHORT = 2'h2,
    ADDR_LONG  = 2'h3
  } addr_mode_type;

endpackage : rxff_pkg

/* rx_frame_filter_ack_decision.sv */
/*
  Receive frame filter and automatic acknowledge decision with the
  dual-network identity registers, reached over Avalon-MM.
  Assumes frame fields come from receive logic on sys_clk, valid while
  rx_done pulses for one cycle, with at least one idle cycle between.
*/
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "rxff_consts.svh"

module rx_frame_filter_ack_decision (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_done,
  input  wire logic        rx_fcs_ok,
  input  wire logic [2:0]  rx_frame_type,
  input  wire logic        rx_ack_request,
  input  wire logic [1:0]  rx_dst_mode,
  input  wire logic [15:0] rx_pan_id,
  input  wire logic [15:0] rx_dst_short,
  input  wire logic [63:0] rx_dst_long,
  input  wire logic        rx_on_net1,
  output logic             data_ind,
  output logic             ack_send,
  output logic             store_frame,
  output logic [3:0]       net0_channel_select,
  output logic [3:0]       net1_channel_select
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [31:0] reg_mask(
    input logic [3:0] idx
  );
    logic [31:0] m;
    m = `RXF_MASK_NONE;
    case (idx)
      `RXF_IDX_CTRL:      m = `RXF_MASK_CTRL;
      `RXF_IDX_N0_CFG,
      `RXF_IDX_N1_CFG:    m = `RXF_MASK_CFG;
      `RXF_IDX_N0_PAN,
      `RXF_IDX_N0_SHORT,
      `RXF_IDX_N1_PAN,
      `RXF_IDX_N1_SHORT:  m = `RXF_MASK_HALF;
      `RXF_IDX_N0_EXT_LO,
      `RXF_IDX_N0_EXT_HI,
      `RXF_IDX_N1_EXT_LO,
      `RXF_IDX_N1_EXT_HI: m = `RXF_MASK_FULL;
      default:            m = `RXF_MASK_NONE;
    endcase
    return m;
  endfunction : reg_mask

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic is_bcast(
    input logic [15:0] v
  );
    return v == `RXF_BROADCAST;
  endfunction : is_bcast

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [31:0] regs_r [0:`RXF_REG_COUNT-1];
  rxff_pkg::bus_state_type bus_r;
  rxff_pkg::bus_state_type bus_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        wait_r;
  logic        last_net0_r;
  logic        last_net1_r;
  logic        data_ind_r;
  logic        ack_send_r;
  logic        store_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic [3:0] idx     = avs_address[5:2];
  wire logic       mapped  = (avs_address[1:0] == 2'b00) &&
                             (idx < 4'(`RXF_REG_COUNT));
  wire logic       req     = avs_read || avs_write;
  wire logic       accept  = req && (bus_r == rxff_pkg::BUS_DONE);
  wire logic       wr_go   = accept && avs_write && mapped &&
                             (idx != `RXF_IDX_STATUS);
  wire logic [31:0] status_word = {30'h0, last_net1_r, last_net0_r};
  wire logic [31:0] rd_word =
    !mapped                    ? `RXF_MASK_NONE :
    idx == `RXF_IDX_STATUS     ? status_word :
    regs_r[idx] & reg_mask(idx);

  // ----------------------------------------
  // Handshake: one wait cycle per request
  // ----------------------------------------
  always_comb begin
    bus_nxt   = bus_r;
    rdata_nxt = rdata_r;
    unique case (bus_r)
      rxff_pkg::BUS_IDLE: begin
        if (req) begin
          bus_nxt   = rxff_pkg::BUS_DONE;
          rdata_nxt = avs_read ? rd_word : `RXF_MASK_NONE;
        end
      end
      rxff_pkg::BUS_DONE: begin
        bus_nxt = rxff_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_r   <= rxff_pkg::BUS_IDLE;
      rdata_r <= `RXF_RESET_VALUE;
      wait_r  <= 1'b1;
    end else begin
      bus_r   <= bus_nxt;
      rdata_r <= rdata_nxt;
      wait_r  <= (bus_nxt != rxff_pkg::BUS_DONE);
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `RXF_REG_COUNT; i++) begin
        regs_r[i] <= `RXF_RESET_VALUE; // RQ18
      end
    end else if (wr_go) begin
      regs_r[idx] <= be_merge(regs_r[idx], avs_writedata, avs_byteenable) &
                     reg_mask(idx); // RQ13 RQ14 RQ15 RQ16 RQ19
    end
  end

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  wire logic [31:0] ctrl_w  = regs_r[`RXF_IDX_CTRL];
  wire logic promisc_en     = ctrl_w[`RXF_CTRL_PROMISC];
  wire logic active_en      = ctrl_w[`RXF_CTRL_ACTIVE]; // RQ18
  wire logic fail_ind_en    = ctrl_w[`RXF_CTRL_FAIL_IND];
  wire logic any_promisc    = promisc_en || active_en;

  wire logic [31:0] n0_cfg  = regs_r[`RXF_IDX_N0_CFG];
  wire logic [31:0] n1_cfg  = regs_r[`RXF_IDX_N1_CFG];

  // Identity of the network the frame arrived on
  wire logic        own_coord = rx_on_net1 ? n1_cfg[`RXF_CFG_COORD] :
                                             n0_cfg[`RXF_CFG_COORD]; // RQ13
  wire logic [15:0] own_pan   = rx_on_net1 ?
    regs_r[`RXF_IDX_N1_PAN][15:0] :
    regs_r[`RXF_IDX_N0_PAN][15:0];
  wire logic [15:0] own_short = rx_on_net1 ?
    regs_r[`RXF_IDX_N1_SHORT][15:0] :
    regs_r[`RXF_IDX_N0_SHORT][15:0];
  wire logic [63:0] own_ext   = rx_on_net1 ?
    {regs_r[`RXF_IDX_N1_EXT_HI], regs_r[`RXF_IDX_N1_EXT_LO]} :
    {regs_r[`RXF_IDX_N0_EXT_HI], regs_r[`RXF_IDX_N0_EXT_LO]};

  // ----------------------------------------
  // Address matching
  // ----------------------------------------
  wire logic pan_bc    = is_bcast(rx_pan_id); // RQ9
  wire logic short_bc  = is_bcast(rx_dst_short); // RQ9
  wire logic pan_own   = (rx_pan_id == own_pan) && !pan_bc;
  wire logic short_own = (rx_dst_short == own_short) && !short_bc;
  wire logic long_own  = (rx_dst_long == own_ext);
  wire logic pan_ok    = pan_own || pan_bc;

  wire logic mode_none  = rx_dst_mode == rxff_pkg::ADDR_NONE;
  wire logic mode_short = rx_dst_mode == rxff_pkg::ADDR_SHORT;
  wire logic mode_long  = rx_dst_mode == rxff_pkg::ADDR_LONG;

  wire logic type_ack  = rx_frame_type == rxff_pkg::FRAME_ACK;
  wire logic type_dc   = (rx_frame_type == rxff_pkg::FRAME_DATA) ||
                         (rx_frame_type == rxff_pkg::FRAME_CMD);
  wire logic type_ok   = type_dc || type_ack ||
                         (rx_frame_type == rxff_pkg::FRAME_BEACON);

  // Normal-mode acceptance filter
  wire logic filt_pass =
    type_ok && (
      (rx_frame_type == rxff_pkg::FRAME_BEACON) ||
      (mode_short && pan_ok && (short_own || short_bc)) ||
      (mode_long && pan_ok && long_own) ||
      (mode_none && type_dc && own_coord && pan_own));

  // Addressed to this node uniquely
  wire logic addr_ack =
    (mode_short && pan_own && short_own) || // RQ17
    (mode_long && pan_ok && long_own) || // RQ11
    (mode_none && own_coord && pan_own);

  // ----------------------------------------
  // Decisions
  // ----------------------------------------
  wire logic ack_nxt = rx_fcs_ok && // RQ8
                       (active_en || !promisc_en) && // RQ4 RQ5 RQ12
                       type_dc && rx_ack_request && addr_ack; // RQ10

  wire logic ind_nxt =
    rx_fcs_ok ?
      (any_promisc || // RQ2 RQ3 RQ6
       (filt_pass && !type_ack)) : // RQ1
      fail_ind_en; // RQ7

  wire logic store_nxt = ind_nxt && (!type_ack || any_promisc); // RQ21

  // ----------------------------------------
  // Result flops
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_ind_r <= 1'b0;
      ack_send_r <= 1'b0;
      store_r    <= 1'b0;
    end else begin
      data_ind_r <= rx_done && ind_nxt;
      ack_send_r <= rx_done && ack_nxt;
      store_r    <= rx_done && store_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_net0_r <= 1'b0;
      last_net1_r <= 1'b0;
    end else if (rx_done) begin
      last_net0_r <= !rx_on_net1; // RQ20
      last_net1_r <= rx_on_net1; // RQ20
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata        = rdata_r;
  assign avs_waitrequest     = wait_r;
  assign data_ind            = data_ind_r;
  assign ack_send            = ack_send_r;
  assign store_frame         = store_r;
  assign net0_channel_select = n0_cfg[3:0]; // RQ19
  assign net1_channel_select = n1_cfg[3:0]; // RQ14

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  chk_bad_fcs_ack: assert property ( // RQ8
    rx_done && !rx_fcs_ok |=> !ack_send)
    else $error("ack sent for bad frame check");

  chk_bad_fcs_drop: assert property ( // RQ1
    rx_done && !rx_fcs_ok && !fail_ind_en |=> !data_ind && !store_frame)
    else $error("bad frame not discarded");

  chk_fail_ind_opt: assert property ( // RQ7
    rx_done && !rx_fcs_ok && fail_ind_en |=> data_ind)
    else $error("failed frame not indicated");

  chk_promisc_ind: assert property ( // RQ3
    rx_done && rx_fcs_ok && promisc_en |=> data_ind ##1 (!data_ind || $past(rx_done)))
    else $error("promiscuous frame not indicated");

  chk_promisc_quiet: assert property ( // RQ4
    rx_done && promisc_en && !active_en |=> !ack_send)
    else $error("ack sent in promiscuous mode");

  chk_active_ind: assert property ( // RQ6
    rx_done && rx_fcs_ok && active_en |=> data_ind)
    else $error("active promiscuous frame not indicated");

  chk_short_bcast: assert property ( // RQ17
    rx_done && mode_short && (pan_bc || short_bc) |=> !ack_send)
    else $error("broadcast short frame acknowledged");

  chk_long_bcast: assert property ( // RQ11
    rx_done && rx_fcs_ok && !(promisc_en && !active_en) && type_dc &&
    rx_ack_request && mode_long && pan_bc && long_own |=> ack_send)
    else $error("broadcast network long match not acknowledged");

  chk_active_store: assert property ( // RQ21
    rx_done && rx_fcs_ok && active_en && type_ack |=> store_frame)
    else $error("ack frame not stored in active promiscuous");

  chk_net_flags: assert property ( // RQ20
    rx_done |=> (last_net1_r == $past(rx_on_net1)) &&
                (last_net0_r != last_net1_r))
    else $error("network flags wrong");

  chk_bus_wait: assert property (
    req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus wait not one cycle");

endmodule : rx_frame_filter_ack_decision

/* radio_node_model.sv */
/*
  Model of a remote radio node handing received frames to the filter.
  Assumes the filter samples the frame fields at the rx_done edge of sys_clk.
*/
`timescale 1ns/1ps

module radio_node_model (
  input  wire logic        sys_clk,
  output logic             rx_done,
  output logic             rx_fcs_ok,
  output logic [2:0]       rx_frame_type,
  output logic             rx_ack_request,
  output logic [1:0]       rx_dst_mode,
  output logic [15:0]      rx_pan_id,
  output logic [15:0]      rx_dst_short,
  output logic [63:0]      rx_dst_long,
  output logic             rx_on_net1
);
  // ----------------------------------------
  // Idle lines and one-frame delivery
  // ----------------------------------------
  initial begin
    rx_done = 1'b0;
    {rx_fcs_ok, rx_frame_type, rx_ack_request, rx_dst_mode} = 7'h00;
    {rx_pan_id, rx_dst_short, rx_dst_long, rx_on_net1} = '0;
  end

  task automatic send(input logic [6:0] hdr, input logic [15:0] pan, input logic [15:0] sa,
                      input logic [63:0] la, input logic n1);
    @(posedge sys_clk);
    rx_done <= 1'b1;
    {rx_fcs_ok, rx_frame_type, rx_ack_request, rx_dst_mode} <= hdr;
    {rx_pan_id, rx_dst_short, rx_dst_long, rx_on_net1} <= {pan, sa, la, n1};
    @(posedge sys_clk);
    rx_done <= 1'b0;
    // Stale fields: show the inverse
    {rx_fcs_ok, rx_frame_type, rx_ack_request, rx_dst_mode} <= ~hdr;
    {rx_pan_id, rx_dst_short, rx_dst_long, rx_on_net1} <= ~{pan, sa, la, n1};
  endtask : send
endmodule : radio_node_model

/* tb_top.sv */
/*
  Self-checking bench for the receive frame filter and acknowledge decision.
  Assumes the design, its package and the remote node model compile first.
*/
`timescale 1ns/1ps

module tb_top;
  // ----------------------------------------
  // Signals and constants
  // ----------------------------------------
  localparam logic [15:0] p0 = 16'h1234, s0 = 16'h0001, p1 = 16'h5678, s1 = 16'h0002;
  localparam logic [15:0] bc = 16'hffff;
  localparam logic [63:0] l0 = 64'h0011_2233_4455_6677, l1 = 64'h8899_aabb_ccdd_eeff;
  localparam logic [2:0]  td = 3'h1, ta = 3'h2, tc = 3'h3;
  localparam logic [1:0]  mn = 2'h0, ms = 2'h2, ml = 2'h3;
  logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable, net0_channel_select, net1_channel_select;
  logic        rx_done, rx_fcs_ok, rx_ack_request, rx_on_net1;
  logic [2:0]  rx_frame_type;
  logic [1:0]  rx_dst_mode;
  logic [15:0] rx_pan_id, rx_dst_short;
  logic [63:0] rx_dst_long;
  logic        data_ind, ack_send, store_frame;
  int          n_fail, checks_done, cycles;

  rx_frame_filter_ack_decision i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_done(rx_done),
    .rx_fcs_ok(rx_fcs_ok), .rx_frame_type(rx_frame_type), .rx_ack_request(rx_ack_request),
    .rx_dst_mode(rx_dst_mode), .rx_pan_id(rx_pan_id), .rx_dst_short(rx_dst_short),
    .rx_dst_long(rx_dst_long), .rx_on_net1(rx_on_net1), .data_ind(data_ind),
    .ack_send(ack_send), .store_frame(store_frame),
    .net0_channel_select(net0_channel_select), .net1_channel_select(net1_channel_select));

  radio_node_model i_node (
    .sys_clk(sys_clk), .rx_done(rx_done), .rx_fcs_ok(rx_fcs_ok),
    .rx_frame_type(rx_frame_type), .rx_ack_request(rx_ack_request),
    .rx_dst_mode(rx_dst_mode), .rx_pan_id(rx_pan_id), .rx_dst_short(rx_dst_short),
    .rx_dst_long(rx_dst_long), .rx_on_net1(rx_on_net1));

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    logic stall;
    @(posedge sys_clk);
    avs_read      <= ~w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    stall = 1'b1;
    while (stall !== 1'b0) begin
      @(posedge sys_clk);
      stall = avs_waitrequest;
      rd = avs_readdata;
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask : wr

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0000_0000, rd);
    check(rd, exp);
  endtask : rdchk

  task automatic frm(input logic fcs, input logic [2:0] ty, input logic ar,
                     input logic [1:0] md, input logic [15:0] pan, input logic [15:0] sa,
                     input logic [63:0] la, input logic n1, input logic [2:0] exp);
    i_node.send({fcs, ty, ar, md}, pan, sa, la, n1);
    #1;
    check(32'({data_ind, ack_send, store_frame}), 32'(exp));
  endtask : frm

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdchk(6'h00, 32'h0000_0000);
    rdchk(6'h04, 32'h0000_0000);
    wr(6'h00, 32'hffff_ffff);
    rdchk(6'h00, 32'h0000_0007);
    wr(6'h00, 32'h0000_0000);
    wr(6'h08, 32'h0000_0015);
    wr(6'h0c, {16'h0000, p0});
    wr(6'h10, {16'h0000, s0});
    wr(6'h14, l0[31:0]);
    wr(6'h18, l0[63:32]);
    wr(6'h1c, 32'h0000_000a);
    wr(6'h20, {16'h0000, p1});
    wr(6'h24, {16'h0000, s1});
    wr(6'h28, l1[31:0]);
    wr(6'h2c, l1[63:32]);
    wr(6'h04, 32'hffff_ffff);
    rdchk(6'h04, 32'h0000_0000);
    rdchk(6'h08, 32'h0000_0015);
    rdchk(6'h0c, {16'h0000, p0});
    avs_byteenable <= 4'h1;
    wr(6'h0c, 32'h0000_ffaa);
    avs_byteenable <= 4'hf;
    rdchk(6'h0c, {16'h0000, p0[15:8], 8'haa});
    wr(6'h0c, {16'h0000, p0});
    rdchk(6'h18, l0[63:32]);
    rdchk(6'h1c, 32'h0000_000a);
    rdchk(6'h24, {16'h0000, s1});
    rdchk(6'h28, l1[31:0]);
    rdchk(6'h30, 32'h0000_0000);
    rdchk(6'h0d, 32'h0000_0000);
    check(32'({net0_channel_select, net1_channel_select}), 32'h0000_005a);
  endtask : t_regs

  task automatic t_normal();
    frm(1'b0, td, 1'b1, ms, p0, s0, l0, 1'b0, 3'b000);
    frm(1'b1, td, 1'b1, ms, p0, s0, l0, 1'b0, 3'b111);
    frm(1'b1, tc, 1'b1, ms, p0, bc, l0, 1'b0, 3'b101);
    frm(1'b1, td, 1'b1, ms, bc, s0, l0, 1'b0, 3'b101);
    frm(1'b1, td, 1'b1, ml, bc, s0, l0, 1'b0, 3'b111);
    frm(1'b1, td, 1'b1, ms, p0, s1, l0, 1'b0, 3'b000);
    frm(1'b1, tc, 1'b1, mn, p0, s0, l0, 1'b0, 3'b111);
    frm(1'b1, ta, 1'b0, mn, p0, s0, l0, 1'b0, 3'b000);
    rdchk(6'h04, 32'h0000_0001);
    frm(1'b1, td, 1'b1, ms, p1, s1, l1, 1'b1, 3'b111);
    rdchk(6'h04, 32'h0000_0002);
    frm(1'b1, td, 1'b1, ml, p1, s1, l0, 1'b1, 3'b000);
    frm(1'b1, tc, 1'b1, mn, p1, s1, l1, 1'b1, 3'b000);
  endtask : t_normal

  task automatic t_promisc();
    wr(6'h00, 32'h0000_0001);
    frm(1'b1, td, 1'b1, ms, p0, s0, l0, 1'b0, 3'b101);
    frm(1'b1, td, 1'b1, ms, p1, s1, l1, 1'b0, 3'b101);
    frm(1'b1, ta, 1'b0, mn, p1, s1, l1, 1'b0, 3'b101);
    frm(1'b0, td, 1'b1, ms, p0, s0, l0, 1'b0, 3'b000);
  endtask : t_promisc

  task automatic t_active();
    wr(6'h00, 32'h0000_0002);
    frm(1'b1, td, 1'b1, ms, p0, s0, l0, 1'b0, 3'b111);
    frm(1'b1, td, 1'b1, ms, p1, s1, l1, 1'b0, 3'b101);
    frm(1'b1, td, 1'b1, ml, bc, s0, l0, 1'b0, 3'b111);
    frm(1'b1, ta, 1'b0, mn, p0, s0, l0, 1'b0, 3'b101);
    frm(1'b0, td, 1'b1, ms, p0, s0, l0, 1'b0, 3'b000);
  endtask : t_active

  task automatic t_fail_ind();
    wr(6'h00, 32'h0000_0004);
    frm(1'b0, td, 1'b1, ms, p0, s0, l0, 1'b0, 3'b101);
    wr(6'h00, 32'h0000_0006);
    frm(1'b0, tc, 1'b1, ml, bc, s0, l0, 1'b0, 3'b101);
  endtask : t_fail_ind

  task automatic t_reset();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdchk(6'h00, 32'h0000_0000);
    rdchk(6'h04, 32'h0000_0000);
    rdchk(6'h08, 32'h0000_0000);
    check(32'({net0_channel_select, net1_channel_select}), 32'h0000_0000);
  endtask : t_reset

  initial begin
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_normal();
    t_promisc();
    t_active();
    t_fail_ind();
    t_reset();
    conclude();
  end
endmodule : tb_top
